// ---- mps_param_store.sv ----
// Top of the motion parameter store: parameter copies, activation, ports.
// Assumes event strobes and write strobes are one-cycle pulses on i_clk.
`timescale 1ns/1ps
`include "mps_map.svh"

module mps_param_store (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_tool_par_we,
    input wire logic i_tool_par_axis,
    input wire logic [`MPS_SEL_W-1:0] i_tool_par_sel,
    input wire logic [`MPS_DATA_W-1:0] i_tool_par_data,
    input wire logic i_tool_pos_we,
    input wire logic [`MPS_IDX_W-1:0] i_tool_pos_idx,
    input wire logic [`MPS_DATA_W-1:0] i_tool_pos_data,
    input wire logic i_tool_ptr_we,
    input wire logic [`MPS_PTR_W-1:0] i_tool_ptr_sel,
    input wire logic [`MPS_IDX_W-1:0] i_tool_ptr_data,
    input wire logic i_host_par_we,
    input wire logic i_host_par_axis,
    input wire logic [`MPS_SEL_W-1:0] i_host_par_sel,
    input wire logic [`MPS_DATA_W-1:0] i_host_par_data,
    input wire logic i_host_pos_we,
    input wire logic [`MPS_IDX_W-1:0] i_host_pos_idx,
    input wire logic [`MPS_DATA_W-1:0] i_host_pos_data,
    input wire logic [`MPS_AXES-1:0] i_origin_start,
    input wire logic i_prog_restart,
    input wire logic i_op_start,
    input wire logic i_manual_step_motion,
    input wire logic i_par_rd_axis,
    input wire logic [`MPS_SEL_W-1:0] i_par_rd_sel,
    input wire logic [`MPS_IDX_W-1:0] i_pos_rd_idx,
    input wire logic i_pos_rd_ind,
    input wire logic [`MPS_PTR_W-1:0] i_ptr_rd_sel,
    output logic [`MPS_DATA_W-1:0] o_par_rdata,
    output logic [`MPS_DATA_W-1:0] o_pos_rdata,
    output logic [`MPS_IDX_W-1:0] o_ptr_rdata,
    output logic o_host_refused,
    output logic o_boot_done
);

    // =================================================================
    // Write arbitration
    // Tool wins a same-cycle clash; the host sees a refusal pulse
    wire host_par_ok = i_host_par_we && !i_tool_par_we &&
                       mps_pkg::mps_host_par(mps_pkg::mps_par_t'(i_host_par_sel));
    wire wr_fire = i_tool_par_we || host_par_ok;
    wire mps_pkg::mps_par_t w_sel = mps_pkg::mps_par_t'(i_tool_par_we ? i_tool_par_sel
                                                                      : i_host_par_sel);
    wire w_ax_raw = i_tool_par_we ? i_tool_par_axis : i_host_par_axis;
    wire w_ax = mps_pkg::mps_unit_level(w_sel) ? `MPS_AXIS_X : w_ax_raw;
    wire [`MPS_DATA_W-1:0] w_data = i_tool_par_we ? i_tool_par_data : i_host_par_data;
    wire mps_pkg::mps_cls_t w_cls = mps_pkg::mps_class(w_sel);
    wire host_pos_ok = i_host_pos_we && !i_tool_pos_we;
    wire next_host_refused = (i_host_par_we && !host_par_ok) ||
                             (i_host_pos_we && !host_pos_ok);

    // =================================================================
    // Parameter copies per axis and group
    logic boot_load;
    logic [`MPS_DATA_W-1:0] pend [`MPS_AXES][`MPS_PAR_N];
    logic [`MPS_DATA_W-1:0] act [`MPS_AXES][`MPS_PAR_N];
    logic [`MPS_AXES-1:0][`MPS_PAR_N-1:0] hit;
    logic [`MPS_AXES-1:0][`MPS_PAR_N-1:0] load_evt;
    logic [`MPS_AXES-1:0][`MPS_PAR_N-1:0] load_now;

    genvar ga, gp;
    generate
        for (ga = 0; ga < `MPS_AXES; ga++)
        begin : g_axis
            for (gp = 0; gp < `MPS_PAR_N; gp++)
            begin : g_par
                localparam mps_pkg::mps_par_t PSEL = mps_pkg::mps_par_t'(4'(gp));
                localparam mps_pkg::mps_cls_t PCLS = mps_pkg::mps_class(PSEL);

                assign hit[ga][gp] = wr_fire && (w_ax == 1'(ga)) && (w_sel == PSEL);
                assign load_evt[ga][gp] = mps_pkg::mps_event(PCLS, i_origin_start[ga],
                                                             i_prog_restart, i_op_start,
                                                             i_manual_step_motion);
                assign load_now[ga][gp] = hit[ga][gp] && (PCLS == mps_pkg::MPS_CLS_NOW);

                // Pending copy has no reset so that it survives a power cycle
                always_ff @(posedge i_clk)
                begin
                    if (hit[ga][gp])
                    begin
                        pend[ga][gp] <= w_data;
                    end
                end

                // A write in the event cycle is taken by that event
                always_ff @(posedge i_clk or negedge i_rst_n)
                begin
                    if (!i_rst_n)
                        act[ga][gp] <= `MPS_DATA_RST;
                    else if (boot_load || load_evt[ga][gp] || load_now[ga][gp])
                        act[ga][gp] <= hit[ga][gp] ? w_data : pend[ga][gp];
                end
            end
        end
    endgenerate

    // =================================================================
    // Power-on load
    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            boot_load <= `MPS_BIT_SET;
            o_boot_done <= `MPS_BIT_CLR;
        end
        else
        begin
            boot_load <= `MPS_BIT_CLR;
            o_boot_done <= `MPS_BIT_SET;
        end
    end

    // =================================================================
    // Position memory and pointers
    wire pos_we = i_tool_pos_we || host_pos_ok;
    wire [`MPS_IDX_W-1:0] pos_widx = i_tool_pos_we ? i_tool_pos_idx : i_host_pos_idx;
    wire [`MPS_DATA_W-1:0] pos_wdata = i_tool_pos_we ? i_tool_pos_data : i_host_pos_data;
    wire [`MPS_IDX_W-1:0] ptr_index;
    wire [`MPS_IDX_W-1:0] pos_raddr = i_pos_rd_ind ? ptr_index : i_pos_rd_idx;

    mps_pos_mem u_pos_mem (
        .i_clk(i_clk),
        .i_rst_n(i_rst_n),
        .i_we(pos_we),
        .i_waddr(pos_widx),
        .i_wdata(pos_wdata),
        .i_raddr(pos_raddr),
        .o_rdata(o_pos_rdata)
    );

    mps_ptr_bank u_ptr_bank (
        .i_clk(i_clk),
        .i_rst_n(i_rst_n),
        .i_we(i_tool_ptr_we),
        .i_wsel(i_tool_ptr_sel),
        .i_wdata(i_tool_ptr_data),
        .i_rsel(i_ptr_rd_sel),
        .o_index(ptr_index)
    );

    // =================================================================
    // Read-back and status
    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            o_par_rdata <= `MPS_DATA_RST;
            o_ptr_rdata <= `MPS_IDX_RST;
            o_host_refused <= `MPS_BIT_CLR;
        end
        else
        begin
            o_par_rdata <= act[i_par_rd_axis][i_par_rd_sel];
            o_ptr_rdata <= ptr_index;
            o_host_refused <= next_host_refused;
        end
    end

    // =================================================================
    // Checks
    logic w_ax_q;
    mps_pkg::mps_par_t w_sel_q;
    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            w_ax_q <= `MPS_AXIS_X;
            w_sel_q <= mps_pkg::MPS_PAR_MECH;
        end
        else
        begin
            w_ax_q <= w_ax;
            w_sel_q <= w_sel;
        end
    end
    wire [`MPS_DATA_W-1:0] act_at_w = act[w_ax][w_sel];
    wire [`MPS_DATA_W-1:0] act_at_wq = act[w_ax_q][w_sel_q];
    wire w_evt = load_evt[w_ax][w_sel];

    a_power_defer: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (wr_fire && w_cls == mps_pkg::MPS_CLS_POWER && !boot_load)
        |=> act_at_wq == $past(act_at_w))
        else $error("power-cycle value applied early");

    a_origin_load: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (i_origin_start[0] && !wr_fire && !boot_load)
        |=> act[0][mps_pkg::MPS_PAR_REF_OFS] == $past(pend[0][mps_pkg::MPS_PAR_REF_OFS]))
        else $error("reference offset not loaded at origin search");

    a_work_restart: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (i_prog_restart && !wr_fire && !boot_load)
        |=> act[1][mps_pkg::MPS_PAR_WORK_OFS] == $past(pend[1][mps_pkg::MPS_PAR_WORK_OFS]))
        else $error("workpiece offset not loaded at restart");

    a_feed_oper: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (i_op_start && !wr_fire && !boot_load)
        |=> act[0][mps_pkg::MPS_PAR_MAX_FEED] == $past(pend[0][mps_pkg::MPS_PAR_MAX_FEED]))
        else $error("feed limit not loaded at operation");

    a_accdec_manual: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (i_manual_step_motion && i_op_start && !i_prog_restart && !wr_fire && !boot_load)
        |=> act[0][mps_pkg::MPS_PAR_ACC] == $past(pend[0][mps_pkg::MPS_PAR_ACC]) &&
            $stable(act[0][mps_pkg::MPS_PAR_IACC]))
        else $error("acc/dec mode handling wrong");

    a_now_write: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (wr_fire && w_cls == mps_pkg::MPS_CLS_NOW) |=> act_at_wq == $past(w_data))
        else $error("immediate parameter not applied");

    a_host_refuse: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (i_host_par_we && !i_tool_par_we &&
         !mps_pkg::mps_host_par(mps_pkg::mps_par_t'(i_host_par_sel)))
        |=> o_host_refused ##1 !o_host_refused || $past(next_host_refused))
        else $error("host write outside its set not refused");

    a_pend_hold: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (wr_fire && w_cls != mps_pkg::MPS_CLS_NOW && !w_evt && !boot_load)
        |=> act_at_wq == $past(act_at_w) ##1 $past(pend[w_ax_q][w_sel_q]) == $past(w_data, 2)
            || $past(wr_fire))
        else $error("deferred value leaked to active copy");

endmodule : mps_param_store

// ---- mps_map.svh ----
// Named constants for the motion parameter store.
// Assumes a single 50 MHz clock and an active-low asynchronous power-on reset.
//
// Contract
// - Position memory holds 2000 entries, index 0-1999.
// - Thirty-two pointer registers index the position memory.
// - Two axes, each with sixteen parameter groups.
// - Unit and mechanical values apply after power-on.
// - Reference origin offset applies at origin search start.
// - Workpiece origin offset applies at program restart.
// - Speed limits apply at next motion operation.
// - Acc/dec by mode; interpolation acc/dec at restart.
// - Memory, zone, servo, others apply when written.
// - Host writes positions and acc/dec times; stored.
`ifndef MPS_MAP_SVH
`define MPS_MAP_SVH

// =====================================================================
// Sizes
`define MPS_DATA_W 32
`define MPS_IDX_W 11
`define MPS_POS_DEPTH 2000
`define MPS_POS_LAST 11'h7cf
`define MPS_PTR_N 32
`define MPS_PTR_W 5
`define MPS_AXES 2
`define MPS_PAR_N 16
`define MPS_SEL_W 4

// =====================================================================
// Reset values
`define MPS_DATA_RST 32'h0000_0000
`define MPS_IDX_RST 11'h000
`define MPS_BIT_CLR 1'b0
`define MPS_BIT_SET 1'b1
`define MPS_AXIS_X 1'b0

`endif

// ---- mps_pkg.sv ----
// Types and decode functions shared by the motion parameter store.
// Assumes mps_map.svh is on the include path.
`include "mps_map.svh"

package mps_pkg;

    // =================================================================
    // Parameter selectors; unit and memory entries live on axis X only
    typedef enum logic [3:0] {
        MPS_PAR_MECH = 4'h0,
        MPS_PAR_REF_OFS = 4'h1,
        MPS_PAR_WORK_OFS = 4'h2,
        MPS_PAR_MAX_FEED = 4'h3,
        MPS_PAR_MAX_IFEED = 4'h4,
        MPS_PAR_HS_ORG = 4'h5,
        MPS_PAR_LS_ORG = 4'h6,
        MPS_PAR_MAX_STEP = 4'h7,
        MPS_PAR_ACC = 4'h8,
        MPS_PAR_DEC = 4'h9,
        MPS_PAR_IACC = 4'ha,
        MPS_PAR_IDEC = 4'hb,
        MPS_PAR_ZONE = 4'hc,
        MPS_PAR_SERVO = 4'hd,
        MPS_PAR_UNIT = 4'he,
        MPS_PAR_MEM = 4'hf
    } mps_par_t;

    // =================================================================
    // Activation classes
    typedef enum logic [2:0] {
        MPS_CLS_POWER = 3'h0,
        MPS_CLS_ORIGIN = 3'h1,
        MPS_CLS_RESTART = 3'h2,
        MPS_CLS_OPER = 3'h3,
        MPS_CLS_ACCDEC = 3'h4,
        MPS_CLS_NOW = 3'h5
    } mps_cls_t;

    function automatic mps_cls_t mps_class(input mps_par_t sel);
        case (sel)
            MPS_PAR_MECH, MPS_PAR_UNIT: return MPS_CLS_POWER;
            MPS_PAR_REF_OFS: return MPS_CLS_ORIGIN;
            MPS_PAR_WORK_OFS, MPS_PAR_IACC, MPS_PAR_IDEC: return MPS_CLS_RESTART;
            MPS_PAR_MAX_FEED, MPS_PAR_MAX_IFEED, MPS_PAR_HS_ORG,
            MPS_PAR_LS_ORG, MPS_PAR_MAX_STEP: return MPS_CLS_OPER;
            MPS_PAR_ACC, MPS_PAR_DEC: return MPS_CLS_ACCDEC;
            default: return MPS_CLS_NOW;
        endcase
    endfunction : mps_class

    // Load event of a deferred class; power and immediate classes never fire here
    function automatic logic mps_event(input mps_cls_t cls, input logic origin,
                                       input logic restart, input logic oper,
                                       input logic manual);
        case (cls)
            MPS_CLS_ORIGIN: return origin;
            MPS_CLS_RESTART: return restart;
            MPS_CLS_OPER: return oper;
            MPS_CLS_ACCDEC: return manual ? oper : restart;
            default: return `MPS_BIT_CLR;
        endcase
    endfunction : mps_event

    function automatic logic mps_host_par(input mps_par_t sel);
        return sel == MPS_PAR_ACC || sel == MPS_PAR_DEC ||
               sel == MPS_PAR_IACC || sel == MPS_PAR_IDEC;
    endfunction : mps_host_par

    function automatic logic mps_unit_level(input mps_par_t sel);
        return sel == MPS_PAR_UNIT || sel == MPS_PAR_MEM;
    endfunction : mps_unit_level

    function automatic logic mps_idx_ok(input logic [`MPS_IDX_W-1:0] idx);
        return idx <= `MPS_POS_LAST;
    endfunction : mps_idx_ok

endpackage : mps_pkg

// ---- mps_pos_mem.sv ----
// Position-data memory in flip-flops, one write and one registered read port.
// Assumes the caller has already arbitrated between write sources.
`timescale 1ns/1ps
`include "mps_map.svh"

module mps_pos_mem (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_we,
    input wire logic [`MPS_IDX_W-1:0] i_waddr,
    input wire logic [`MPS_DATA_W-1:0] i_wdata,
    input wire logic [`MPS_IDX_W-1:0] i_raddr,
    output logic [`MPS_DATA_W-1:0] o_rdata
);

    // =================================================================
    // Storage
    logic [`MPS_DATA_W-1:0] mem [`MPS_POS_DEPTH];
    wire wr_ok = i_we && mps_pkg::mps_idx_ok(i_waddr);
    wire rd_ok = mps_pkg::mps_idx_ok(i_raddr);

    // Data store needs no reset; out-of-range writes are dropped
    always_ff @(posedge i_clk)
    begin
        if (wr_ok)
        begin
            mem[i_waddr] <= i_wdata;
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
            o_rdata <= `MPS_DATA_RST;
        else
            o_rdata <= rd_ok ? mem[i_raddr] : `MPS_DATA_RST;
    end

    // =================================================================
    // Checks
    a_pos_write_read: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (wr_ok ##1 (i_raddr == $past(i_waddr)) && !i_we)
        |=> o_rdata == $past(i_wdata, 2))
        else $error("position entry not read back");

    a_pos_range: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        !rd_ok |=> o_rdata == `MPS_DATA_RST)
        else $error("out-of-range index returned data");

endmodule : mps_pos_mem

// ---- mps_ptr_bank.sv ----
// Bank of pointer registers, each an index into the position memory.
// Assumes one writer; the read is combinational and registered by the caller.
`timescale 1ns/1ps
`include "mps_map.svh"

module mps_ptr_bank (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_we,
    input wire logic [`MPS_PTR_W-1:0] i_wsel,
    input wire logic [`MPS_IDX_W-1:0] i_wdata,
    input wire logic [`MPS_PTR_W-1:0] i_rsel,
    output logic [`MPS_IDX_W-1:0] o_index
);

    // =================================================================
    // Registers
    logic [`MPS_IDX_W-1:0] ptr [`MPS_PTR_N];
    // A pointer never holds an index outside the memory
    wire wr_ok = i_we && mps_pkg::mps_idx_ok(i_wdata);

    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            for (int i = 0; i < `MPS_PTR_N; i++)
                ptr[i] <= `MPS_IDX_RST;
        end
        else if (wr_ok)
        begin
            ptr[i_wsel] <= i_wdata;
        end
    end

    assign o_index = ptr[i_rsel];

    // =================================================================
    // Checks
    a_ptr_store_read: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (wr_ok ##1 (i_rsel == $past(i_wsel)) && !i_we)
        |-> o_index == $past(i_wdata))
        else $error("pointer value not read back");

    a_ptr_reject: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (i_we && !wr_ok) |=> ptr[$past(i_wsel)] == $past(ptr[i_wsel]))
        else $error("bad pointer value was stored");

endmodule : mps_ptr_bank

// ---- mps_host_model.sv ----
// Host controller model writing through the shared data area.
// Assumes the store takes each request on the rising edge of i_clk.
`timescale 1ns/1ps
`include "mps_map.svh"

module mps_host_model (
    input wire logic i_clk,
    output logic o_par_we,
    output logic o_par_axis,
    output logic [`MPS_SEL_W-1:0] o_par_sel,
    output logic [`MPS_DATA_W-1:0] o_par_data,
    output logic o_pos_we,
    output logic [`MPS_IDX_W-1:0] o_pos_idx,
    output logic [`MPS_DATA_W-1:0] o_pos_data
);
    // ================================================================
    // Idle levels
    initial
    begin
        o_par_we = 1'b0;
        o_par_axis = 1'b0;
        o_par_sel = 4'h0;
        o_par_data = 32'h0;
        o_pos_we = 1'b0;
        o_pos_idx = 11'h0;
        o_pos_data = 32'h0;
    end

    // ================================================================
    // Writes; released lines flip so a stale word never looks valid
    task automatic par_write(input logic ax, input logic [3:0] sel, input logic [31:0] d);
        @(negedge i_clk);
        o_par_we = 1'b1;
        o_par_axis = ax;
        o_par_sel = sel;
        o_par_data = d;
        @(negedge i_clk);
        o_par_we = 1'b0;
        o_par_axis = ~ax;
        o_par_sel = ~sel;
        o_par_data = ~d;
    endtask : par_write

    task automatic pos_write(input logic [10:0] idx, input logic [31:0] d);
        @(negedge i_clk);
        o_pos_we = 1'b1;
        o_pos_idx = idx;
        o_pos_data = d;
        @(negedge i_clk);
        o_pos_we = 1'b0;
        o_pos_idx = ~idx;
        o_pos_data = ~d;
    endtask : pos_write
endmodule : mps_host_model

// ---- motion_parameter_store_tb_top.sv ----
// Self-checking bench for the motion parameter store.
// Assumes the host model drives the shared data area side.
`timescale 1ns/1ps
`include "mps_map.svh"

module motion_parameter_store_tb_top;
    logic i_clk;
    logic i_rst_n;
    logic t_pwe;
    logic t_pax;
    logic [3:0] t_psel;
    logic [31:0] t_pd;
    logic t_xwe;
    logic [10:0] t_xi;
    logic [31:0] t_xd;
    logic t_qwe;
    logic [4:0] t_qs;
    logic [10:0] t_qd;
    logic h_pwe;
    logic h_pax;
    logic [3:0] h_psel;
    logic [31:0] h_pd;
    logic h_xwe;
    logic [10:0] h_xi;
    logic [31:0] h_xd;
    logic [1:0] org;
    logic rst;
    logic op;
    logic man;
    logic rax;
    logic [3:0] rsel;
    logic [10:0] ridx;
    logic rind;
    logic [4:0] rps;
    logic [31:0] par_q;
    logic [31:0] pos_q;
    logic [10:0] ptr_q;
    logic refd;
    logic boot;
    logic [31:0] act [2][16];
    logic [31:0] pend [2][16];
    int n_mismatch = 0;
    int n_tests = 0;
    int cyc = 0;

    mps_param_store dut (.i_clk(i_clk), .i_rst_n(i_rst_n),
        .i_tool_par_we(t_pwe), .i_tool_par_axis(t_pax), .i_tool_par_sel(t_psel),
        .i_tool_par_data(t_pd), .i_tool_pos_we(t_xwe), .i_tool_pos_idx(t_xi),
        .i_tool_pos_data(t_xd), .i_tool_ptr_we(t_qwe), .i_tool_ptr_sel(t_qs),
        .i_tool_ptr_data(t_qd), .i_host_par_we(h_pwe), .i_host_par_axis(h_pax),
        .i_host_par_sel(h_psel), .i_host_par_data(h_pd), .i_host_pos_we(h_xwe),
        .i_host_pos_idx(h_xi), .i_host_pos_data(h_xd), .i_origin_start(org),
        .i_prog_restart(rst), .i_op_start(op), .i_manual_step_motion(man),
        .i_par_rd_axis(rax), .i_par_rd_sel(rsel), .i_pos_rd_idx(ridx),
        .i_pos_rd_ind(rind), .i_ptr_rd_sel(rps), .o_par_rdata(par_q),
        .o_pos_rdata(pos_q), .o_ptr_rdata(ptr_q), .o_host_refused(refd),
        .o_boot_done(boot));

    mps_host_model host (.i_clk(i_clk), .o_par_we(h_pwe), .o_par_axis(h_pax),
        .o_par_sel(h_psel), .o_par_data(h_pd), .o_pos_we(h_xwe), .o_pos_idx(h_xi),
        .o_pos_data(h_xd));

    always #10 i_clk = ~i_clk;

    // ================================================================
    // Reporting
    task automatic final_report;
        $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : final_report

    // Bound well above the fewer than one thousand cycles the run needs
    always @(posedge i_clk)
    begin
        cyc++;
        if (cyc == 8000)
        begin
            n_mismatch++;
            final_report();
        end
    end

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_tests++;
        if (g !== e)
        begin
            n_mismatch++;
            $display("FAIL %s exp %h got %h", nm, e, g);
        end
    endtask : chk

    // ================================================================
    // Reference: 0 power, 1 origin, 2 restart, 3 operation, 4 acc/dec, 5 now
    function automatic int cls(input int s);
        case (s)
            0, 14: return 0;
            1: return 1;
            2, 10, 11: return 2;
            3, 4, 5, 6, 7: return 3;
            8, 9: return 4;
            default: return 5;
        endcase
    endfunction : cls

    function automatic logic due(input int a, input int s, input logic [1:0] o,
                                 input logic r, input logic p);
        case (cls(s))
            1: return o[a];
            2: return r;
            3: return p;
            4: return man ? p : r;
            default: return 1'b0;
        endcase
    endfunction : due

    // ================================================================
    // Drivers
    task automatic do_reset(input int n);
        @(negedge i_clk);
        i_rst_n = 1'b0;
        #1;
        chk("rst_data", 32'h0, par_q | pos_q);
        chk("rst_misc", 32'h0, {19'h0, ptr_q, refd, boot});
        repeat (n) @(negedge i_clk);
        i_rst_n = 1'b1;
        act = pend;
        @(negedge i_clk);
        chk("boot_done", 32'h1, {31'h0, boot});
    endtask : do_reset

    task automatic tw(input int a, input int s, input logic [31:0] d);
        @(negedge i_clk);
        t_pwe = 1'b1;
        t_pax = 1'(a);
        t_psel = 4'(s);
        t_pd = d;
        @(negedge i_clk);
        t_pwe = 1'b0;
        pend[a][s] = d;
        if (cls(s) == 5)
            act[a][s] = d;
    endtask : tw

    task automatic hw(input int a, input int s, input logic [31:0] d, input logic ok);
        logic r0;
        host.par_write(1'(a), 4'(s), d);
        r0 = refd;
        @(negedge i_clk);
        chk("refused", {31'h0, !ok}, {31'h0, r0 | refd});
        chk("refused_once", 32'h0, {31'h0, r0 & refd});
        if (ok)
            pend[a][s] = d;
    endtask : hw

    task automatic chk_all;
        for (int a = 0; a < 2; a++)
            for (int s = 0; s < 16; s++)
                if (a == 0 || s < 14)
                begin
                    @(negedge i_clk);
                    rax = 1'(a);
                    rsel = 4'(s);
                    @(negedge i_clk);
                    chk($sformatf("par_%0d_%0d", a, s), act[a][s], par_q);
                end
    endtask : chk_all

    task automatic fire(input logic [1:0] o, input logic r, input logic p);
        @(negedge i_clk);
        org = o;
        rst = r;
        op = p;
        @(negedge i_clk);
        org = 2'h0;
        rst = 1'b0;
        op = 1'b0;
        for (int a = 0; a < 2; a++)
            for (int s = 0; s < 16; s++)
                if (due(a, s, o, r, p))
                    act[a][s] = pend[a][s];
        chk_all();
    endtask : fire

    task automatic wall(input logic [7:0] g);
        for (int a = 0; a < 2; a++)
            for (int s = 0; s < 16; s++)
                if (a == 0 || s < 14)
                    tw(a, s, {g, 15'h0, 1'(a), 4'h0, 4'(s)});
    endtask : wall

    task automatic tp(input int i, input logic [31:0] d);
        @(negedge i_clk);
        t_xwe = 1'b1;
        t_xi = 11'(i);
        t_xd = d;
        @(negedge i_clk);
        t_xwe = 1'b0;
    endtask : tp

    task automatic tq(input int s, input int v);
        @(negedge i_clk);
        t_qwe = 1'b1;
        t_qs = 5'(s);
        t_qd = 11'(v);
        @(negedge i_clk);
        t_qwe = 1'b0;
    endtask : tq

    task automatic rp(input logic ind, input int i, input int s, input logic [31:0] e,
                      input int q);
        @(negedge i_clk);
        rind = ind;
        ridx = 11'(i);
        rps = 5'(s);
        @(negedge i_clk);
        chk("pos", e, pos_q);
        chk("ptr", 32'(q), {21'h0, ptr_q});
    endtask : rp

    // ================================================================
    // Scenarios
    task automatic t_activation;
        wall(8'h01);
        do_reset(3);
        chk_all();
        wall(8'h02);
        chk_all();
        fire(2'b10, 1'b0, 1'b0);
        fire(2'b01, 1'b0, 1'b0);
        fire(2'b00, 1'b0, 1'b1);
        fire(2'b00, 1'b1, 1'b0);
        man = 1'b1;
        wall(8'h03);
        fire(2'b00, 1'b1, 1'b0);
        fire(2'b00, 1'b0, 1'b1);
        do_reset(3);
        chk_all();
        man = 1'b0;
        $display("test activation done");
    endtask : t_activation

    task automatic t_host;
        hw(1, 8, 32'h4801_0008, 1'b1);
        hw(0, 11, 32'h4800_000b, 1'b1);
        hw(0, 12, 32'h4800_000c, 1'b0);
        hw(1, 3, 32'h4801_0003, 1'b0);
        // Tool and host in one cycle: tool wins
        fork
            tw(0, 13, 32'h5500_000d);
            hw(1, 9, 32'h4801_0009, 1'b0);
        join
        fire(2'b00, 1'b1, 1'b0);
        $display("test host done");
    endtask : t_host

    task automatic t_pos;
        tp(0, 32'ha5a5_0000);
        tp(1999, 32'h5a5a_07cf);
        tp(2000, 32'h1111_07d0);
        host.pos_write(11'h005, 32'h0000_0005);
        fork
            tp(7, 32'h0000_0007);
            host.pos_write(11'h007, 32'hffff_0007);
        join
        chk("pos_refused", 32'h1, {31'h0, refd});
        tq(0, 1999);
        tq(31, 5);
        tq(31, 2000);
        rp(1'b0, 0, 0, 32'ha5a5_0000, 1999);
        rp(1'b0, 2000, 31, 32'h0, 5);
        rp(1'b1, 0, 0, 32'h5a5a_07cf, 1999);
        rp(1'b1, 0, 31, 32'h0000_0005, 5);
        rp(1'b0, 7, 0, 32'h0000_0007, 1999);
        do_reset(3);
        rp(1'b1, 0, 31, 32'ha5a5_0000, 0);
        $display("test position done");
    endtask : t_pos

    initial
    begin
        i_clk = 1'b0;
        i_rst_n = 1'b0;
        {t_pwe, t_pax, t_psel, t_pd, t_xwe, t_xi, t_xd, t_qwe, t_qs, t_qd} = '0;
        {org, rst, op, man, rax, rsel, ridx, rind, rps} = '0;
        // Fill pending copies under reset so only the unused axis Y unit and memory copies boot unknown
        wall(8'h01);
        do_reset(20);
        t_activation();
        t_host();
        t_pos();
        final_report();
    end
endmodule : motion_parameter_store_tb_top
